// ==== rtdf_cpu_model.sv ====
// Controller side that reads the allocated word area
`timescale 1ns/1ps
module rtdf_cpu_model
    import rtdf_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic [WORD_W-1:0] word_rd_data_ff,
    output logic      [ADDR_W-1:0] word_addr
);
    initial word_addr = 5'h00;
    // One word read, address held across the sampling edge
    task automatic read_word(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d);
        @(negedge clk_sys);
        word_addr = a;
        @(negedge clk_sys);
        d = word_rd_data_ff;
    endtask
endmodule

// ==== rtdf_fmt.sv ====
// Per-loop range check and word encoding of one process value
`timescale 1ns/1ps
module rtdf_fmt
    import rtdf_pkg::*;
(
    input  wire logic signed [WORD_W-1:0] meas_c,
    input  wire rtdf_cfg_s                cfg,
    output logic             [WORD_W-1:0] pv_word,
    output logic                          sens_err,
    output logic             [WORD_W-1:0] alarm_val
);
    logic signed [19:0] c_ext;
    logic signed [19:0] f_val;
    logic signed [19:0] val;
    logic signed [19:0] set_lo;
    logic signed [19:0] set_hi;
    logic signed [19:0] bcd_lo;
    logic signed [19:0] bcd_hi;
    logic signed [19:0] clamped;
    logic        [19:0] mag;
    logic        [15:0] bcd;

    always_comb begin
        c_ext  = 20'(meas_c);
        f_val  = (c_ext * F_MUL) / F_DIV + F_OFS;
        val    = cfg.unit_fahr ? f_val : c_ext;
        set_lo = cfg.unit_fahr ? F_SET_LO : C_SET_LO;
        set_hi = cfg.unit_fahr ? F_SET_HI : C_SET_HI;
        sens_err = (val < set_lo - IND_MARGIN) || (val > set_hi + IND_MARGIN);
        bcd_lo = (DISP_LO > set_lo) ? DISP_LO : set_lo;
        bcd_hi = (DISP_HI < set_hi) ? DISP_HI : set_hi;
        if (cfg.tc_b_sel) begin
            bcd_lo = B_IND_LO;
        end
        clamped = val;
        if (val < bcd_lo) begin
            clamped = bcd_lo;
        end else if (val > bcd_hi) begin
            clamped = bcd_hi;
        end
        mag = clamped[19] ? 20'(-clamped) : 20'(clamped);
        bcd[3:0]   = 4'(mag % 20'd10);
        bcd[7:4]   = 4'((mag / 20'd10) % 20'd10);
        bcd[11:8]  = 4'((mag / 20'd100) % 20'd10);
        bcd[15:12] = clamped[19] ? BCD_NEG_NIB : 4'((mag / 20'd1000) % 20'd10);
        if (sens_err) begin
            pv_word = PV_FAULT;
        end else if (cfg.fmt_binary) begin
            pv_word = val[15:0];
        end else begin
            pv_word = bcd;
        end
        alarm_val = sens_err ? ALARM_HIGH : val[15:0];
    end
endmodule

// ==== rtdf_monitor.sv ====
// Concurrent checks on the formatter's top-level ports
`timescale 1ns/1ps
module rtdf_monitor
    import rtdf_pkg::*;
(
    input wire logic                     clk_sys,
    input wire logic                     rst_b,
    input wire rtdf_cfg_s                cfg_pin,
    input wire logic signed [WORD_W-1:0] meas_c [NLOOP],
    input wire logic        [NLOOP-1:0]  ctrl_req,
    input wire logic signed [WORD_W-1:0] alarm_limit [NLOOP],
    input wire logic        [ADDR_W-1:0] word_addr,
    input wire logic        [WORD_W-1:0] word_rd_data_ff,
    input wire logic        [NLOOP-1:0]  ctrl_out_ff,
    input wire logic        [NLOOP-1:0]  alarm_ff,
    input wire logic        [NLOOP-1:0]  sens_err_ff,
    input wire logic                     type_bad_ff
);
    rtdf_cfg_s  cfg_d_ff;
    logic [1:0] stab_ff;
    // Counts edges with unchanged config pins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_d_ff <= '0;
            stab_ff  <= 2'h0;
        end else begin
            cfg_d_ff <= cfg_pin;
            stab_ff  <= (cfg_pin != cfg_d_ff) ? 2'h0 : ((stab_ff == 2'h3) ? 2'h3 : stab_ff + 2'h1);
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_bin_celsius: assert property (stab_ff == 2'h3 && cfg_d_ff.fmt_binary && !cfg_d_ff.unit_fahr
        && word_addr == 5'h03 && $past(meas_c[0]) inside {[-16'sd2200:16'sd6700]}
        |=> word_rd_data_ff == $past(meas_c[0], 2)) else $error("celsius binary word wrong");
    a_bin_fahr: assert property (stab_ff == 2'h3 && cfg_d_ff.fmt_binary && cfg_d_ff.unit_fahr
        && word_addr == 5'h03 && $past(meas_c[0]) inside {[-16'sd1900:16'sd6000]}
        |=> word_rd_data_ff == 16'(int'($past(meas_c[0], 2)) * 18 / 10 + 320))
        else $error("fahrenheit binary word wrong");
    a_err_low: assert property (stab_ff == 2'h3 && !cfg_d_ff.unit_fahr
        && meas_c[1] < -16'sd2200 |=> sens_err_ff[1]) else $error("low error missed");
    a_err_clears: assert property (stab_ff == 2'h3 && !cfg_d_ff.unit_fahr
        && meas_c[1] inside {[-16'sd2200:16'sd6700]} |=> !sens_err_ff[1]) else $error("flag stuck");
    a_ctrl_gated: assert property (stab_ff == 2'h3 |=> ctrl_out_ff[1] ==
        ($past(ctrl_req[1]) && !sens_err_ff[1])) else $error("control output not gated");
    a_alarm_high: assert property (sens_err_ff[1] |->
        alarm_ff[1] == ($past(alarm_limit[1]) != 16'sh7fff)) else $error("alarm not high on error");
    a_fault_word: assert property (word_addr == 5'h04 && sens_err_ff[1]
        |=> word_rd_data_ff == PV_FAULT) else $error("fault code missing");
    a_flag_word: assert property (word_addr == 5'h09
        |=> word_rd_data_ff == {1'b0, $past(sens_err_ff[1]), 14'h0}) else $error("flag word wrong");
    a_unmapped_zero: assert property (word_addr > 5'h13
        |=> word_rd_data_ff == 16'h0) else $error("unmapped word not zero");
    c_err: cover property ($rose(sens_err_ff[1]));
    c_type_bad: cover property ($rose(type_bad_ff));
    c_flag_read: cover property (word_addr == 5'h09 && sens_err_ff[1]);
endmodule
bind rtdf_top rtdf_monitor u_mon (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_pin(cfg_pin),
    .meas_c(meas_c), .ctrl_req(ctrl_req), .alarm_limit(alarm_limit), .word_addr(word_addr),
    .word_rd_data_ff(word_rd_data_ff), .ctrl_out_ff(ctrl_out_ff), .alarm_ff(alarm_ff),
    .sens_err_ff(sens_err_ff), .type_bad_ff(type_bad_ff));

// ==== rtdf_pkg.sv ====
// Shared constants and types for the resistance-thermometer value formatter
package rtdf_pkg;
    localparam int NLOOP  = 4;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 5;

    // Allocated word area, local word index from base word
    localparam logic [ADDR_W-1:0] N_WORDS           = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_PV   [NLOOP]  = '{5'h03, 5'h04, 5'h0d, 5'h0e};
    localparam logic [ADDR_W-1:0] OFS_FLAG [NLOOP]  = '{5'h08, 5'h09, 5'h12, 5'h13};
    localparam int                SENS_ERR_BIT      = 14;

    // Data codes
    localparam logic [WORD_W-1:0] PV_FAULT     = 16'hcccc;
    localparam logic [3:0]        BCD_NEG_NIB  = 4'hf;
    localparam logic [WORD_W-1:0] ALARM_HIGH   = 16'h7fff;

    // Ranges in tenths of a degree
    localparam logic signed [19:0] C_SET_LO   = 20'shff830;
    localparam logic signed [19:0] C_SET_HI   = 20'sh01964;
    localparam logic signed [19:0] F_SET_LO   = 20'shff448;
    localparam logic signed [19:0] F_SET_HI   = 20'sh02ee0;
    localparam logic signed [19:0] IND_MARGIN = 20'sh000c8;
    localparam logic signed [19:0] DISP_LO    = 20'shffc19;
    localparam logic signed [19:0] DISP_HI    = 20'sh0270f;
    localparam logic signed [19:0] B_IND_LO   = 20'sh00000;
    localparam logic signed [19:0] COMP_LO    = 20'shffc19;
    localparam logic signed [19:0] COMP_HI    = 20'sh003e7;

    // Celsius to Fahrenheit in tenths: c*18/10 + 320
    localparam logic signed [19:0] F_MUL  = 20'sh00012;
    localparam logic signed [19:0] F_DIV  = 20'sh0000a;
    localparam logic signed [19:0] F_OFS  = 20'sh00140;
    localparam logic signed [19:0] DEC_SCALE = 20'sh0000a;

    // Input type settings allowed for this input
    localparam logic [3:0] TYPE_PT  = 4'h0;
    localparam logic [3:0] TYPE_JPT = 4'h1;

    typedef struct packed {
        logic       fmt_binary;
        logic       unit_fahr;
        logic       tc_b_sel;
        logic [3:0] input_type;
    } rtdf_cfg_s;
endpackage

// ==== rtdf_top.sv ====
// Process value formatter, sensor error flags, output gating and set point upkeep
`timescale 1ns/1ps
// What this block does
// - Celsius binary values in tenths span F830 through FFFF to 1964.
// - Fahrenheit binary values in tenths span F448 through FFFF to 2EE0.
// - Tenth-degree BCD indication limited to -99.9..999.9, F nibble marks negative.
// - More than 200 tenths outside the setting range: sensor error, flag set, value word reads CCCC.
// - Sensor error forces that loop's control output off.
// - Alarm still works, treating the value as abnormally high during error.
// - BCD beyond indication limits but within setting range holds the limit.
// - B-type thermocouple lower indication limit is zero degrees.
// - After a type change, set points and compensations clamp into range.
// - After a type change between tenth-degree and other types, stored values rescale by moving the decimal point.
// - Loop values sit at word offsets 3, 4, 13 and 14.
// - Sensor error flags sit in bit 14 of words 8, 9, 18, 19.
// - Switches pick BCD or binary storage and Celsius or Fahrenheit.
// - Fahrenheit is Celsius times 1.8 plus 32.
// - Device occupies twenty consecutive words from its base.
module rtdf_top
    import rtdf_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     rst_b,
    input  wire rtdf_cfg_s                cfg_pin,
    input  wire logic signed [WORD_W-1:0] meas_c [NLOOP],
    input  wire logic        [NLOOP-1:0]  ctrl_req,
    input  wire logic signed [WORD_W-1:0] alarm_limit [NLOOP],
    input  wire logic        [ADDR_W-1:0] word_addr,
    output logic             [WORD_W-1:0] word_rd_data_ff,
    input  wire logic                     sv_wr_en,
    input  wire logic                     sv_wr_comp,
    input  wire logic        [1:0]        sv_wr_loop,
    input  wire logic signed [WORD_W-1:0] sv_wr_data,
    output logic signed      [WORD_W-1:0] set_point_value_ff [NLOOP],
    output logic signed      [WORD_W-1:0] comp_value_ff [NLOOP],
    output logic             [NLOOP-1:0]  ctrl_out_ff,
    output logic             [NLOOP-1:0]  alarm_ff,
    output logic             [NLOOP-1:0]  sens_err_ff,
    output logic                          type_bad_ff
);
    rtdf_cfg_s          cfg_meta_ff;
    rtdf_cfg_s          cfg_ff;
    logic [3:0]         last_type_ff;
    logic [WORD_W-1:0]  pv_ff [NLOOP];
    logic [WORD_W-1:0]  pv_word [NLOOP];
    logic [WORD_W-1:0]  alarm_val [NLOOP];
    logic [NLOOP-1:0]   err_now;
    logic               type_chg;
    logic [WORD_W-1:0]  nxt_rd_data;

    // Switch and strap pins synchroniser
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_meta_ff <= '0;
            cfg_ff      <= '0;
        end else begin
            cfg_meta_ff <= cfg_pin;
            cfg_ff      <= cfg_meta_ff;
        end
    end

    for (genvar i = 0; i < NLOOP; i++) begin : g_loop
        rtdf_fmt u_fmt (
            .meas_c    (meas_c[i]),
            .cfg       (cfg_ff),
            .pv_word   (pv_word[i]),
            .sens_err  (err_now[i]),
            .alarm_val (alarm_val[i])
        );
    end

    // Process value words
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NLOOP; i++) begin
                pv_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NLOOP; i++) begin
                pv_ff[i] <= pv_word[i];
            end
        end
    end

    // Sensor error flags
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sens_err_ff <= '0;
        end else begin
            sens_err_ff <= err_now;
        end
    end

    // Control output gating
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_out_ff <= '0;
        end else begin
            ctrl_out_ff <= ctrl_req & ~err_now;
        end
    end

    // Alarm compare, signed
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            alarm_ff <= '0;
        end else begin
            for (int i = 0; i < NLOOP; i++) begin
                alarm_ff[i] <= $signed(alarm_val[i]) > alarm_limit[i];
            end
        end
    end

    // Allocated word read port
    always_comb begin
        nxt_rd_data = '0;
        for (int i = 0; i < NLOOP; i++) begin
            if (word_addr == OFS_PV[i]) begin
                nxt_rd_data = pv_ff[i];
            end
            if (word_addr == OFS_FLAG[i]) begin
                nxt_rd_data[SENS_ERR_BIT] = sens_err_ff[i];
            end
        end
        if (word_addr >= N_WORDS) begin
            nxt_rd_data = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            word_rd_data_ff <= '0;
        end else begin
            word_rd_data_ff <= nxt_rd_data;
        end
    end

    // Input type legality
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            type_bad_ff <= 1'b0;
        end else begin
            type_bad_ff <= (cfg_ff.input_type != TYPE_PT) &&
                           (cfg_ff.input_type != TYPE_JPT);
        end
    end

    function automatic logic signed [WORD_W-1:0] adjust(
        input logic signed [WORD_W-1:0] v,
        input logic [3:0]               old_t,
        input logic [3:0]               new_t,
        input logic signed [19:0]       lo,
        input logic signed [19:0]       hi
    );
        logic signed [19:0] x;
        logic               old_tenths;
        logic               new_tenths;
        x          = 20'(v);
        old_tenths = (old_t == TYPE_PT) || (old_t == TYPE_JPT);
        new_tenths = (new_t == TYPE_PT) || (new_t == TYPE_JPT);
        if (old_tenths && !new_tenths) begin
            x = x / DEC_SCALE;
        end else if (!old_tenths && new_tenths) begin
            x = x * DEC_SCALE;
        end
        if (x < lo) begin
            x = lo;
        end else if (x > hi) begin
            x = hi;
        end
        return x[WORD_W-1:0];
    endfunction

    assign type_chg = (cfg_ff.input_type != last_type_ff);

    // Last applied input type
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            last_type_ff <= TYPE_PT;
        end else begin
            last_type_ff <= cfg_ff.input_type;
        end
    end

    // Set point store, write lost in a type-change cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NLOOP; i++) begin
                set_point_value_ff[i] <= '0;
            end
        end else begin
            if (type_chg) begin
                for (int i = 0; i < NLOOP; i++) begin
                    set_point_value_ff[i] <= adjust(set_point_value_ff[i], last_type_ff,
                        cfg_ff.input_type,
                        cfg_ff.unit_fahr ? F_SET_LO : C_SET_LO,
                        cfg_ff.unit_fahr ? F_SET_HI : C_SET_HI);
                end
            end else if (sv_wr_en && !sv_wr_comp) begin
                set_point_value_ff[sv_wr_loop] <= sv_wr_data;
            end
        end
    end

    // Compensation store, write lost in a type-change cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NLOOP; i++) begin
                comp_value_ff[i] <= '0;
            end
        end else begin
            if (type_chg) begin
                for (int i = 0; i < NLOOP; i++) begin
                    comp_value_ff[i] <= adjust(comp_value_ff[i], last_type_ff,
                        cfg_ff.input_type, COMP_LO, COMP_HI);
                end
            end else if (sv_wr_en && sv_wr_comp) begin
                comp_value_ff[sv_wr_loop] <= sv_wr_data;
            end
        end
    end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the process value formatter
`timescale 1ns/1ps
module testbench
    import rtdf_pkg::*;
;
    logic clk_sys, rst_b, sv_wr_en, sv_wr_comp;
    rtdf_cfg_s cfg;
    logic signed [WORD_W-1:0] meas_c [NLOOP], alarm_limit [NLOOP], sv_wr_data;
    logic signed [WORD_W-1:0] sp [NLOOP], cp [NLOOP];
    logic [NLOOP-1:0] ctrl_req, ctrl_out, alarm, serr;
    logic [ADDR_W-1:0] word_addr;
    logic [WORD_W-1:0] rd_data;
    logic [1:0] sv_wr_loop;
    logic type_bad;
    int num_errors, comparisons, cyc;
    rtdf_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_pin(cfg), .meas_c(meas_c),
        .ctrl_req(ctrl_req), .alarm_limit(alarm_limit), .word_addr(word_addr),
        .word_rd_data_ff(rd_data), .sv_wr_en(sv_wr_en), .sv_wr_comp(sv_wr_comp),
        .sv_wr_loop(sv_wr_loop), .sv_wr_data(sv_wr_data), .set_point_value_ff(sp),
        .comp_value_ff(cp), .ctrl_out_ff(ctrl_out), .alarm_ff(alarm), .sens_err_ff(serr),
        .type_bad_ff(type_bad));
    rtdf_cpu_model cpu (.clk_sys(clk_sys), .word_rd_data_ff(rd_data), .word_addr(word_addr));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task tally_and_finish;
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        logic [15:0] d;
        cpu.read_word(a, d);
        chk(d, e);
    endtask
    task setm(input int i, input int v);
        @(negedge clk_sys);
        meas_c[i] = 16'(v);
        repeat (2) @(negedge clk_sys);
    endtask
    task setc(input logic b, input logic f, input logic t, input logic [3:0] ty);
        @(negedge clk_sys);
        cfg = '{b, f, t, ty};
        repeat (5) @(negedge clk_sys);
    endtask
    task wr(input logic c, input logic [1:0] l, input int d);
        @(negedge clk_sys);
        {sv_wr_en, sv_wr_comp, sv_wr_loop, sv_wr_data} = {1'b1, c, l, 16'(d)};
        @(negedge clk_sys);
        sv_wr_en = 1'b0;
    endtask
    task automatic t_bin;
        int v[4] = '{-2000, 6500, -1, 0};
        int w[4] = '{-1900, 6000, 0, 1000};
        setc(1'b1, 1'b0, 1'b0, TYPE_PT);
        for (int i = 0; i < 4; i++) setm(i, v[i]);
        for (int i = 0; i < 4; i++) rd(OFS_PV[i], 16'(v[i]));
        setc(1'b1, 1'b1, 1'b0, TYPE_JPT);
        for (int i = 0; i < 4; i++) setm(i, w[i]);
        for (int i = 0; i < 4; i++) rd(OFS_PV[i], 16'(w[i] * 18 / 10 + 320));
    endtask
    task t_err;
        setc(1'b1, 1'b0, 1'b0, TYPE_PT);
        ctrl_req = 4'hf;
        alarm_limit[2] = -16'sd10;
        setm(1, -2201);
        setm(3, 6701);
        rd(5'h04, 16'hcccc);
        rd(5'h09, 16'h4000);
        rd(5'h13, 16'h4000);
        chk({12'h0, serr}, 16'h000a);
        chk({12'h0, ctrl_out}, 16'h0005);
        chk({12'h0, alarm}, 16'h000e);
        setm(1, 0);
        setm(3, 0);
        rd(5'h09, 16'h0000);
        rd(5'h0e, 16'h0000);
        chk({12'h0, ctrl_out}, 16'h000f);
        rd(5'h15, 16'h0000);
    endtask
    task automatic t_bcd;
        int v[4] = '{1234, -500, -1500, 6600};
        int e[4] = '{'h1234, 'hf500, 'hf999, 'h6500};
        setc(1'b0, 1'b0, 1'b0, TYPE_PT);
        for (int i = 0; i < 4; i++) setm(i, v[i]);
        for (int i = 0; i < 4; i++) rd(OFS_PV[i], 16'(e[i]));
        setc(1'b0, 1'b0, 1'b1, TYPE_PT);
        setm(0, -50);
        rd(5'h03, 16'h0000);
        setc(1'b0, 1'b1, 1'b0, TYPE_PT);
        setm(0, 6500);
        rd(5'h03, 16'h9999);
    endtask
    task t_type;
        setc(1'b1, 1'b0, 1'b0, TYPE_PT);
        wr(1'b0, 2'h2, 6000);
        wr(1'b1, 2'h2, 500);
        setc(1'b1, 1'b0, 1'b0, 4'h2);
        chk({15'h0, type_bad}, 16'h0001);
        chk(sp[2], 16'd600);
        chk(cp[2], 16'd50);
        wr(1'b0, 2'h2, 900);
        wr(1'b1, 2'h2, 150);
        setc(1'b1, 1'b0, 1'b0, TYPE_PT);
        chk(sp[2], 16'd6500);
        chk(cp[2], 16'd999);
        chk({15'h0, type_bad}, 16'h0000);
    endtask
    initial begin
        {rst_b, sv_wr_en, sv_wr_comp, sv_wr_loop, sv_wr_data, ctrl_req, cfg} = '0;
        meas_c = '{default: '0};
        alarm_limit = '{default: '0};
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys) rst_b = 1'b1;
        t_bin();
        t_err();
        t_bcd();
        t_type();
        tally_and_finish();
    end
endmodule
